// >>> design/vab_unit.sv
// viterbi acs butterfly datapath with result fifo
// assumes the sequencer drives requests synchronous to mclk
//
// Behaviour
// - Sixteen states are tracked per symbol interval as eight butterflies of two new metrics each.
// - Each new state metric is chosen between two candidates of branch metric plus an old path metric.
// - The branch metric is the first symbol times the first sign plus the second symbol times the second sign.
// - The first sign is +1 for even and -1 for odd index; the second equals it for 0-3 and negates it for 4-7.
// - The dual add-sub op forms old 2J plus metric and old 2J+1 minus metric for new state J.
// - The dual sub-add op forms old 2J minus metric and old 2J+1 plus metric for new state J+8.
// - Compare-select keeps the larger of the upper and lower halves as the new metric.
// - The 16-bit transition history is updated on every compare-select, except in a cycle where history_clear clears it instead.
// - Each compare-select shifts the history left one and loads bit 0 with the compare result flag.
`timescale 1ns/1ps
`include "vab_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// ring buffer of results; full at DEPTH entries
// head data reads straight from the array, so it holds until popped
module vab_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_fifo_bound: assert property (count <= (AW+1)'(DEPTH))
    else $error("fifo count past depth");
  a_fifo_full_block: assert property (count == (AW+1)'(DEPTH) |-> !in_ready)
    else $error("fifo accepts while full");
  a_fifo_hold_head: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("fifo head moved without pop");
endmodule

////////////////////////////////////////////////////////////////////////////////
// one lane of the split accumulator: W-bit add or subtract
// the carry out of the top bit is dropped here, so no lane disturbs its neighbour
module vab_half_addsub #(
  parameter int W = `VAB_HALF_W
) (
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  input wire logic subtract,
  output logic [W-1:0] sum
);
  // subtract as a plus inverted b plus one, which keeps a single adder per lane
  wire [W:0] full = {1'b0, a} + {1'b0, subtract ? ~b : b} + (W+1)'(subtract);
  assign sum = full[W-1:0];
endmodule

////////////////////////////////////////////////////////////////////////////////
module vab_unit #(
  parameter int HALF_W = `VAB_HALF_W,
  parameter int HIST_W = `VAB_HIST_W,
  parameter int FIFO_DEPTH = `VAB_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire vab_pkg::vab_req_t req,
  output logic res_valid,
  input wire logic res_ready,
  output vab_pkg::vab_res_t res,
  input wire logic history_clear,
  output logic [HIST_W-1:0] transition_history,
  output logic [3:0] bfly_count,
  output logic interval_done
);
  typedef logic signed [HALF_W-1:0] half_t;

  // branch metric from soft symbols and code signs
  wire neg_first = req.idx[0];
  wire neg_second = req.idx[0] ^ (req.idx >= 3'(`VAB_SIGN2_SPLIT));
  wire half_t term0 = neg_first ? -req.sd0 : req.sd0;
  wire half_t term1 = neg_second ? -req.sd1 : req.sd1;
  wire half_t branch_metric = half_t'(term0 + term1);

  // variants swap which accumulator gets which op; the two results are identical
  wire is_fwd = req.op == vab_pkg::VAB_OP_FWD;
  // dual mode: each lane is its own HALF_W adder, so carries stop at the split
  half_t acc_a_hi;
  half_t acc_a_lo;
  half_t acc_b_hi;
  half_t acc_b_lo;

  vab_half_addsub #(
    .W(HALF_W)
  ) acc_a_hi_i (
    .a(req.old_even),
    .b(branch_metric),
    .subtract(!is_fwd),
    .sum(acc_a_hi)
  );

  vab_half_addsub #(
    .W(HALF_W)
  ) acc_a_lo_i (
    .a(req.old_odd),
    .b(branch_metric),
    .subtract(is_fwd),
    .sum(acc_a_lo)
  );

  vab_half_addsub #(
    .W(HALF_W)
  ) acc_b_hi_i (
    .a(req.old_even),
    .b(branch_metric),
    .subtract(is_fwd),
    .sum(acc_b_hi)
  );

  vab_half_addsub #(
    .W(HALF_W)
  ) acc_b_lo_i (
    .a(req.old_odd),
    .b(branch_metric),
    .subtract(!is_fwd),
    .sum(acc_b_lo)
  );
  // new J uses add-sub pair, new J+8 the sub-add pair
  wire half_t j_hi = is_fwd ? acc_a_hi : acc_b_hi;
  wire half_t j_lo = is_fwd ? acc_a_lo : acc_b_lo;
  wire half_t j8_hi = is_fwd ? acc_b_hi : acc_a_hi;
  wire half_t j8_lo = is_fwd ? acc_b_lo : acc_a_lo;

  // compare result flag set when the lower half wins
  wire flag_j = j_lo > j_hi;
  wire flag_j8 = j8_lo > j8_hi;
  wire half_t sel_j = flag_j ? j_lo : j_hi;
  wire half_t sel_j8 = flag_j8 ? j8_lo : j8_hi;

  // op none is taken but leaves no trace, so idle slots cost nothing
  wire fifo_in_ready;
  wire op_valid = req.op != vab_pkg::VAB_OP_NONE;
  wire fire = req_valid && fifo_in_ready;
  wire do_bfly = fire && op_valid;
  assign req_ready = fifo_in_ready;

  vab_pkg::vab_res_t fifo_in;
  assign fifo_in = '{
    idx: req.idx,
    new_lo: sel_j,
    new_hi: sel_j8,
    flag_lo: flag_j,
    flag_hi: flag_j8
  };

  ////////////////////////////////////////////////////////////////////////////
  // two compare-selects per butterfly: J first, then J+8
  wire [HIST_W-1:0] next_history = {transition_history[HIST_W-3:0], flag_j, flag_j8};
  wire last_bfly = bfly_count == 4'(`VAB_NUM_BFLY - 1);

  // clear beats a same-cycle butterfly so a fresh interval starts clean
  always_ff @(posedge mclk)
  begin
    if (!rst_n || history_clear)
      transition_history <= '0;
    else if (do_bfly)
      transition_history <= next_history;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      bfly_count <= '0;
      interval_done <= 1'b0;
    end
    else
    begin
      // one-cycle pulse; the sequencer saves the history on it
      interval_done <= do_bfly && last_bfly;
      if (do_bfly)
        bfly_count <= last_bfly ? 4'h0 : bfly_count + 4'h1;
    end
  end

  // results wait here so the consumer can stall without losing butterflies
  vab_fifo #(
    .WIDTH($bits(vab_pkg::vab_res_t)),
    .DEPTH(FIFO_DEPTH)
  ) vab_fifo_i (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(do_bfly),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_hist_shift: assert property (do_bfly && !history_clear |=>
    transition_history == {$past(transition_history[HIST_W-3:0]), $past(flag_j), $past(flag_j8)})
    else $error("history shift wrong");
  a_hist_hold: assert property (!do_bfly && !history_clear |=> $stable(transition_history))
    else $error("history changed without compare-select");
  a_select_max: assert property (do_bfly |-> sel_j >= j_hi && sel_j >= j_lo)
    else $error("selected metric not the larger");
  a_branch_sign: assert property (req_valid && req.idx == 3'h5 |-> branch_metric == half_t'(req.sd1 - req.sd0))
    else $error("branch sign for index five wrong");
  a_branch_even: assert property (req_valid && req.idx == 3'h2 |-> branch_metric == half_t'(req.sd0 + req.sd1))
    else $error("branch metric for index two wrong");
  a_dual_addsub: assert property (req_valid && is_fwd |->
    j_hi == half_t'(req.old_even + branch_metric) && j_lo == half_t'(req.old_odd - branch_metric))
    else $error("add-sub candidates wrong");
  a_dual_subadd: assert property (req_valid && req.op == vab_pkg::VAB_OP_REV |->
    j8_hi == half_t'(req.old_even - branch_metric) && j8_lo == half_t'(req.old_odd + branch_metric))
    else $error("sub-add candidates wrong");
  a_half_isolate: assert property (req_valid && op_valid |->
    half_t'(j_hi - branch_metric) == req.old_even && half_t'(j8_lo - branch_metric) == req.old_odd)
    else $error("upper half disturbed by lower");
  a_branch_zero: assert property (req_valid && req.idx == 3'h0 |-> branch_metric == half_t'(req.sd0 + req.sd1))
    else $error("branch metric for index zero wrong");
  a_branch_odd: assert property (req_valid && req.idx == 3'h1 |-> branch_metric == half_t'(-req.sd0 - req.sd1))
    else $error("branch metric for index one wrong");
  a_branch_split: assert property (req_valid && req.idx == 3'h4 |-> branch_metric == half_t'(req.sd0 - req.sd1))
    else $error("branch metric for index four wrong");
  a_branch_seven: assert property (req_valid && req.idx == 3'h7 |-> branch_metric == half_t'(req.sd1 - req.sd0))
    else $error("branch metric for index seven wrong");
  a_select_j8: assert property (do_bfly |-> sel_j8 >= j8_hi && sel_j8 >= j8_lo)
    else $error("selected upper-state metric not the larger");
  a_tie_upper: assert property (do_bfly && j_lo == j_hi |-> !flag_j && sel_j == j_hi)
    else $error("tie did not keep the upper half");

  // sequencing checks
  a_clear_history: assert property (history_clear |=> transition_history == '0)
    else $error("history not cleared");
  a_count_range: assert property (bfly_count <= 4'(`VAB_NUM_BFLY - 1))
    else $error("butterfly count out of range");
  a_done_pulse: assert property (interval_done |=> !interval_done)
    else $error("interval end longer than one cycle");
  a_stall_hold: assert property (!req_ready |=> $stable(bfly_count))
    else $error("butterfly counted while stalled");
  a_interval_end: assert property (do_bfly && last_bfly |=> interval_done && bfly_count == 4'h0)
    else $error("interval end missed");
  a_fifo_push: assert property (do_bfly |=> res_valid)
    else $error("result not queued");

  c_fwd_bfly: cover property (do_bfly && is_fwd);
  c_rev_bfly: cover property (do_bfly && !is_fwd);
  c_full_interval: cover property (interval_done);
  c_fifo_stall: cover property (req_valid && !req_ready);
  c_tie_select: cover property (do_bfly && j_lo == j_hi);
endmodule

// >>> design/vab_regs.svh
// constants for the viterbi add-compare-select butterfly unit
// assumes inclusion by bare name from the design package or module
`ifndef VAB_REGS_SVH
`define VAB_REGS_SVH
`define VAB_NUM_STATES 16
`define VAB_NUM_BFLY 8
`define VAB_HALF_W 16
`define VAB_HIST_W 16
`define VAB_FIFO_DEPTH 4
`define VAB_SIGN2_SPLIT 4
`endif

// >>> design/vab_pkg.sv
// types for the viterbi add-compare-select butterfly unit
// assumes vab_regs.svh is on the include path
`include "vab_regs.svh"
package vab_pkg;
  typedef enum logic [1:0] {
    VAB_OP_NONE,
    VAB_OP_FWD,
    VAB_OP_REV
  } vab_op_t;

  typedef struct packed {
    vab_op_t op;
    logic [2:0] idx;
    logic signed [`VAB_HALF_W-1:0] sd0;
    logic signed [`VAB_HALF_W-1:0] sd1;
    logic signed [`VAB_HALF_W-1:0] old_even;
    logic signed [`VAB_HALF_W-1:0] old_odd;
  } vab_req_t;

  typedef struct packed {
    logic [2:0] idx;
    logic signed [`VAB_HALF_W-1:0] new_lo;
    logic signed [`VAB_HALF_W-1:0] new_hi;
    logic flag_lo;
    logic flag_hi;
  } vab_res_t;
endpackage

// >>> dv/vab_seq_model.sv
// sequencer model: issues one interval of eight butterflies
// assumes the bench fills tab before pulsing start
`timescale 1ns/1ps
module vab_seq_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic req_ready,
  input wire logic interval_done,
  input wire logic [15:0] transition_history,
  output logic req_valid,
  output vab_pkg::vab_req_t req,
  output logic [15:0] saved_history
);
  vab_pkg::vab_req_t tab [8];
  logic [2:0] n;

  // odd steps use the reverse variant; the metric is still subtracted in two lanes either way
  function automatic vab_pkg::vab_req_t pick(input logic [2:0] k);
    vab_pkg::vab_req_t r;
    r = tab[k];
    r.op = k[0] ? vab_pkg::VAB_OP_REV : vab_pkg::VAB_OP_FWD;
    return r;
  endfunction

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      req_valid <= 1'b0;
      req <= '0;
      n <= 3'h0;
      saved_history <= 16'h0000;
    end
    else
    begin
      if (start && !req_valid)
      begin
        req_valid <= 1'b1;
        req <= pick(3'h0);
        n <= 3'h0;
      end
      else if (req_valid && req_ready)
      begin
        // after the last one the fields move on, so stale data is not held
        req_valid <= (n != 3'h7);
        req <= pick(n + 3'h1);
        n <= n + 3'h1;
      end
      if (interval_done)
        saved_history <= transition_history;
    end
  end
endmodule

// >>> dv/viterbi_acs_butterfly_unit_test.sv
// self-checking bench for the acs butterfly unit
// assumes design files and the sequencer model compile first
`timescale 1ns/1ps
module viterbi_acs_butterfly_unit_test;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic res_ready = 1'b0;
  logic history_clear = 1'b0;
  logic start = 1'b0;
  logic req_valid, req_ready, res_valid, interval_done;
  vab_pkg::vab_req_t req;
  vab_pkg::vab_res_t res;
  logic [15:0] transition_history, saved_history, exp_hist;
  logic [3:0] bfly_count;
  vab_pkg::vab_res_t exp_q [8];
  int mismatches = 0;
  int comparisons = 0;
  always #2.5 mclk = ~mclk;
  vab_unit vab_unit_i (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .res_valid(res_valid), .res_ready(res_ready), .res(res), .history_clear(history_clear),
    .transition_history(transition_history), .bfly_count(bfly_count), .interval_done(interval_done));
  vab_seq_model vab_seq_model_i (.mclk(mclk), .rst_n(rst_n), .start(start), .req_ready(req_ready),
    .interval_done(interval_done), .transition_history(transition_history), .req_valid(req_valid),
    .req(req), .saved_history(saved_history));
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [36:0] seen, input logic [36:0] want, input string what);
    comparisons++;
    if (seen !== want)
    begin
      mismatches++;
      $display("MISMATCH at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask
  task automatic step(inout int g);
    @(posedge mclk);
    #1;
    g++;
    if (g > 200)
    begin
      mismatches++;
      summarize();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // tie mode makes both J candidates equal; entry 3 wraps and carries
  task automatic fill(input logic tie);
    vab_pkg::vab_req_t r;
    logic signed [15:0] m, ah, al, bh, bl;
    exp_hist = 16'h0000;
    for (int k = 0; k < 8; k++)
    begin
      r.op = vab_pkg::VAB_OP_NONE;
      r.idx = 3'(k);
      r.sd0 = 16'h0030 - 16'(k * 17);
      r.sd1 = 16'(k * 7) - 16'h000c;
      r.old_even = (k == 3) ? 16'h7ffe : 16'(k * 256);
      r.old_odd = (k == 3) ? 16'hfffe : 16'(k * 80) - 16'h0100;
      m = (r.idx[0] ? -r.sd0 : r.sd0) + ((r.idx[0] ^ r.idx[2]) ? -r.sd1 : r.sd1);
      if (tie)
        r.old_odd = r.old_even + m + m;
      ah = r.old_even + m;
      al = r.old_odd - m;
      bh = r.old_even - m;
      bl = r.old_odd + m;
      exp_q[k].idx = r.idx;
      exp_q[k].flag_lo = al > ah;
      exp_q[k].new_lo = (al > ah) ? al : ah;
      exp_q[k].flag_hi = bl > bh;
      exp_q[k].new_hi = (bl > bh) ? bl : bh;
      exp_hist = {exp_hist[13:0], exp_q[k].flag_lo, exp_q[k].flag_hi};
      vab_seq_model_i.tab[k] = r;
    end
  endtask
  task automatic run_interval(input logic tie, input logic stall);
    int got;
    int g;
    int best;
    int j;
    int pos;
    logic want;
    logic signed [15:0] pm [16];
    got = 0;
    g = 0;
    fill(tie);
    @(posedge mclk) history_clear <= 1'b1;
    @(posedge mclk) history_clear <= 1'b0;
    #1 check(37'(transition_history), 37'h0, "history after clear");
    @(posedge mclk) start <= 1'b1;
    res_ready <= !stall;
    @(posedge mclk) start <= 1'b0;
    if (stall)
    begin
      while (req_ready !== 1'b0)
        step(g);
      check(37'(bfly_count), 37'h4, "taken before fifo full");
    end
    @(posedge mclk) res_ready <= 1'b1;
    #1;
    while (got < 8)
    begin
      if (res_valid === 1'b1)
      begin
        check(37'(res), 37'(exp_q[got]), "butterfly result");
        got++;
      end
      step(g);
    end
    check(37'(transition_history), 37'(exp_hist), "history after interval");
    check(37'(saved_history), 37'(exp_hist), "history at interval end");
    check(37'({bfly_count, res_valid}), 37'h0, "count and fifo empty");
    // one traceback step from the best new state, read from the saved decisions
    for (int k = 0; k < 8; k++)
    begin
      pm[k] = exp_q[k].new_lo;
      pm[k + 8] = exp_q[k].new_hi;
    end
    best = 0;
    for (int s = 1; s < 16; s++)
      if (pm[s] > pm[best])
        best = s;
    j = best % 8;
    pos = 15 - 2 * j - best / 8;
    want = (best < 8) ? exp_q[j].flag_lo : exp_q[j].flag_hi;
    check(37'(saved_history[pos]), 37'(want), "traceback decision");
    $display("interval test done, stall %0b tie %0b", stall, tie);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    #1 check(37'({interval_done, req_ready, res_valid, transition_history, bfly_count}), 37'h200000, "reset values");
    run_interval(1'b0, 1'b1);
    run_interval(1'b1, 1'b0);
    summarize();
  end
endmodule
